// ==== design/aclm_pkg.sv ====
`default_nettype none
package aclm_pkg;
  // Register byte offsets
  localparam logic [7:0] ARP_CFG_OFS = 8'h00;
  localparam logic [7:0] ICMP_CFG_OFS = 8'h04;
  localparam logic [7:0] SPORT_MODE_OFS = 8'h08;
  localparam logic [7:0] SPORT_RANGE_OFS = 8'h0c;
  localparam logic [7:0] DPORT_MODE_OFS = 8'h10;
  localparam logic [7:0] DPORT_RANGE_OFS = 8'h14;
  localparam logic [7:0] TCP_FLAG_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1c;
  // Field positions
  localparam int ICMP_TYPE_SPEC_BIT = 0;
  localparam int ICMP_CODE_SPEC_BIT = 1;
  localparam int ICMP_TYPE_LSB = 8;
  localparam int ICMP_CODE_LSB = 16;
  localparam int RANGE_LO_LSB = 0;
  localparam int RANGE_HI_LSB = 16;
  localparam int STATUS_HIT_BIT = 0;
  localparam int STATUS_SEEN_BIT = 1;
  localparam int STATUS_CNT_LSB = 16;
  localparam int NUM_FLAGS = 5;
  // Flag order in the flag register and flag input: fin syn psh ack urg
  localparam int FLAG_FIN = 0;
  localparam int FLAG_SYN = 1;
  localparam int FLAG_PSH = 2;
  localparam int FLAG_ACK = 3;
  localparam int FLAG_URG = 4;
  // Reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // Protocol type for IP in ARP frames
  localparam logic [15:0] PROTO_IP = 16'h0800;
  // Three-way criterion settings
  typedef enum logic [1:0] {
    TRI_ANY = 2'h0,
    TRI_ZERO = 2'h1,
    TRI_ONE = 2'h2
  } aclm_tri_t;
  // Port criterion modes
  typedef enum logic [1:0] {
    PM_ANY = 2'h0,
    PM_SPECIFIC = 2'h1,
    PM_RANGE = 2'h2
  } aclm_pmode_t;
endpackage : aclm_pkg
`default_nettype wire

// ==== design/aclm_port_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface aclm_port_if;
  logic [1:0] mode;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] port;
  logic ok;
  modport cfg (output mode, output lo, output hi, output port, input ok);
  modport cmp (input mode, input lo, input hi, input port, output ok);
endinterface : aclm_port_if
`default_nettype wire

// ==== design/aclm_port_match.sv ====
`timescale 1ns/100ps
`default_nettype none
module aclm_port_match (
  aclm_port_if.cmp pif // Port criterion and frame port
);
  wire is_spec;
  wire is_range;
  wire eq_hit;
  wire rng_hit;
  assign is_spec = (pif.mode == aclm_pkg::PM_SPECIFIC);
  assign is_range = (pif.mode == aclm_pkg::PM_RANGE);
  assign eq_hit = (pif.port == pif.lo);
  // Inclusive bounds; an inverted range never hits
  assign rng_hit = (pif.port >= pif.lo) && (pif.port <= pif.hi);
  // Unused mode code behaves as don't-care
  assign pif.ok = is_spec ? eq_hit : (is_range ? rng_hit : 1'b1);
endmodule : aclm_port_match
`default_nettype wire

// ==== design/aclm_entry_match.sv ====
// Overview of operation
// - ARP protocol type: 0 rejects IP 0x800, 1 requires it, any ignores.
// - ICMP type is don't-care or must equal configured 8-bit value.
// - ICMP code is don't-care or must equal configured 8-bit value.
// - Source port criterion selects don't-care, specific value or range.
// - Specific source port: frame port must equal the 16-bit value.
// - Range source port: frame port must lie within 16-bit bounds.
// - Destination port criterion selects don't-care, specific value or range.
// - Specific destination port: frame port must equal the 16-bit value.
// - Range destination port: frame port must lie within 16-bit bounds.
// - FIN setting: 0 blocks FIN set, 1 requires FIN set, any ignores.
// - SYN setting: 0 blocks SYN set, 1 requires SYN set, any ignores.
// - PSH setting: 0 blocks PSH set, 1 requires PSH set, any ignores.
// - ACK setting: 0 blocks ACK set, 1 requires ACK set, any ignores.
// - URG setting: 0 blocks URG set, 1 requires URG set, any ignores.
`timescale 1ns/100ps
`default_nettype none
module aclm_entry_match (
  input wire logic clk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error on unmapped address
  input wire logic frm_valid, // Parsed header valid, one cycle
  input wire logic frm_is_arp, // Frame is ARP or RARP
  input wire logic frm_is_icmp, // Frame is ICMP
  input wire logic frm_is_tcp, // Frame is TCP
  input wire logic frm_is_udp, // Frame is UDP
  input wire logic [15:0] frm_arp_proto, // ARP protocol type
  input wire logic [7:0] frm_icmp_type, // ICMP type
  input wire logic [7:0] frm_icmp_code, // ICMP code
  input wire logic [15:0] frm_src_port, // TCP/UDP source port
  input wire logic [15:0] frm_dst_port, // TCP/UDP destination port
  input wire logic [4:0] frm_tcp_flags, // FIN SYN PSH ACK URG, bit 0 first
  output logic hit_valid, // Verdict valid, one cycle
  output logic hit // Frame hits the filter_entry
);
  localparam int NF = aclm_pkg::NUM_FLAGS;

  // Ok when the three-way setting accepts the condition
  function automatic logic tri_ok(input logic [1:0] setting, input logic cond);
    logic r;
    r = 1'b1;
    if (setting == aclm_pkg::TRI_ZERO) begin
      r = !cond;
    end else if (setting == aclm_pkg::TRI_ONE) begin
      r = cond;
    end
    return r;
  endfunction : tri_ok

  logic [1:0] arp_cfg_q;
  logic [31:0] icmp_cfg_q;
  logic [1:0] sport_mode_q;
  logic [31:0] sport_range_q;
  logic [1:0] dport_mode_q;
  logic [31:0] dport_range_q;
  logic [2*NF-1:0] flag_cfg_q;
  logic hit_q;
  logic hit_d;
  logic hit_valid_q;
  logic seen_q;
  logic [15:0] hit_cnt_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // APB decode
  wire acc_cyc;
  wire wr_fire;
  wire sel_arp;
  wire sel_icmp;
  wire sel_smode;
  wire sel_srange;
  wire sel_dmode;
  wire sel_drange;
  wire sel_flag;
  wire sel_stat;
  wire mapped;
  wire [31:0] rd_mux;
  wire [31:0] status_word;

  // One wait state so read data can come from a register
  assign acc_cyc = psel && penable && !pready_q;
  assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;
  assign sel_arp = (paddr == aclm_pkg::ARP_CFG_OFS);
  assign sel_icmp = (paddr == aclm_pkg::ICMP_CFG_OFS);
  assign sel_smode = (paddr == aclm_pkg::SPORT_MODE_OFS);
  assign sel_srange = (paddr == aclm_pkg::SPORT_RANGE_OFS);
  assign sel_dmode = (paddr == aclm_pkg::DPORT_MODE_OFS);
  assign sel_drange = (paddr == aclm_pkg::DPORT_RANGE_OFS);
  assign sel_flag = (paddr == aclm_pkg::TCP_FLAG_OFS);
  assign sel_stat = (paddr == aclm_pkg::STATUS_OFS);
  assign mapped = sel_arp | sel_icmp | sel_smode | sel_srange | sel_dmode | sel_drange |
                  sel_flag | sel_stat;
  assign status_word = {hit_cnt_q, 14'h0000, seen_q, hit_q};
  assign rd_mux = sel_arp ? {30'h0000_0000, arp_cfg_q} :
                  sel_icmp ? icmp_cfg_q :
                  sel_smode ? {30'h0000_0000, sport_mode_q} :
                  sel_srange ? sport_range_q :
                  sel_dmode ? {30'h0000_0000, dport_mode_q} :
                  sel_drange ? dport_range_q :
                  sel_flag ? {22'h00_0000, flag_cfg_q} :
                  sel_stat ? status_word : 32'h0000_0000;

  // Read data stays zero outside a read answer
  wire pready_d;
  wire [31:0] prdata_d;
  wire pslverr_d;
  assign pready_d = acc_cyc;
  assign prdata_d = (acc_cyc && !pwrite) ? rd_mux : 32'h0000_0000;
  assign pslverr_d = acc_cyc && !mapped;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Per-register write strobes; STATUS has none, so writes there are dropped
  wire wr_arp;
  wire wr_icmp;
  wire wr_smode;
  wire wr_srange;
  wire wr_dmode;
  wire wr_drange;
  wire wr_flag;
  wire [31:0] icmp_cfg_d;
  assign wr_arp = wr_fire && sel_arp;
  assign wr_icmp = wr_fire && sel_icmp;
  assign wr_smode = wr_fire && sel_smode;
  assign wr_srange = wr_fire && sel_srange;
  assign wr_dmode = wr_fire && sel_dmode;
  assign wr_drange = wr_fire && sel_drange;
  assign wr_flag = wr_fire && sel_flag;
  // Unused ICMP bits are cleared so they read back as zero
  assign icmp_cfg_d = pwdata & 32'h00ff_ff03;

  // Configuration registers; writes land at the completing edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arp_cfg_q <= aclm_pkg::CFG_RST[1:0];
    end else if (wr_arp) begin
      arp_cfg_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      icmp_cfg_q <= aclm_pkg::CFG_RST;
    end else if (wr_icmp) begin
      icmp_cfg_q <= icmp_cfg_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sport_mode_q <= aclm_pkg::CFG_RST[1:0];
    end else if (wr_smode) begin
      sport_mode_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sport_range_q <= aclm_pkg::CFG_RST;
    end else if (wr_srange) begin
      sport_range_q <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dport_mode_q <= aclm_pkg::CFG_RST[1:0];
    end else if (wr_dmode) begin
      dport_mode_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dport_range_q <= aclm_pkg::CFG_RST;
    end else if (wr_drange) begin
      dport_range_q <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_cfg_q <= aclm_pkg::CFG_RST[2*NF-1:0];
    end else if (wr_flag) begin
      flag_cfg_q <= pwdata[2*NF-1:0];
    end
  end

  // Criteria
  wire arp_ok;
  wire icmp_type_ok;
  wire icmp_code_ok;
  wire icmp_ok;
  wire src_ok;
  wire dst_ok;
  wire ports_ok;
  wire [NF-1:0] flag_ok;
  wire flags_ok;
  wire l4_frame;

  assign arp_ok = !frm_is_arp || tri_ok(arp_cfg_q, frm_arp_proto == aclm_pkg::PROTO_IP);
  wire icmp_type_spec;
  wire icmp_code_spec;
  wire [7:0] icmp_type_val;
  wire [7:0] icmp_code_val;
  assign icmp_type_spec = icmp_cfg_q[aclm_pkg::ICMP_TYPE_SPEC_BIT];
  assign icmp_code_spec = icmp_cfg_q[aclm_pkg::ICMP_CODE_SPEC_BIT];
  assign icmp_type_val = icmp_cfg_q[aclm_pkg::ICMP_TYPE_LSB +: 8];
  assign icmp_code_val = icmp_cfg_q[aclm_pkg::ICMP_CODE_LSB +: 8];
  assign icmp_type_ok = !icmp_type_spec || (frm_icmp_type == icmp_type_val);
  assign icmp_code_ok = !icmp_code_spec || (frm_icmp_code == icmp_code_val);
  assign icmp_ok = !frm_is_icmp || (icmp_type_ok && icmp_code_ok);

  aclm_port_if src_if ();
  aclm_port_if dst_if ();
  assign src_if.mode = sport_mode_q;
  assign src_if.lo = sport_range_q[aclm_pkg::RANGE_LO_LSB +: 16];
  assign src_if.hi = sport_range_q[aclm_pkg::RANGE_HI_LSB +: 16];
  assign src_if.port = frm_src_port;
  assign dst_if.mode = dport_mode_q;
  assign dst_if.lo = dport_range_q[aclm_pkg::RANGE_LO_LSB +: 16];
  assign dst_if.hi = dport_range_q[aclm_pkg::RANGE_HI_LSB +: 16];
  assign dst_if.port = frm_dst_port;

  aclm_port_match u_src (
    .pif(src_if)
  );
  aclm_port_match u_dst (
    .pif(dst_if)
  );

  assign src_ok = src_if.ok;
  assign dst_ok = dst_if.ok;
  assign l4_frame = frm_is_tcp || frm_is_udp;
  assign ports_ok = !l4_frame || (src_ok && dst_ok);

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_flag
      // Flags only exist in TCP headers
      assign flag_ok[gi] = !frm_is_tcp ||
        tri_ok(flag_cfg_q[2*gi +: 2], frm_tcp_flags[gi]);
    end
  endgenerate
  assign flags_ok = &flag_ok;

  assign hit_d = arp_ok && icmp_ok && ports_ok && flags_ok;
  // Counter wraps; software takes the difference of two reads
  wire [15:0] hit_cnt_d;
  assign hit_cnt_d = hit_cnt_q + 16'h0001;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_valid_q <= 1'b0;
    end else begin
      hit_valid_q <= frm_valid;
    end
  end

  // Verdict holds until the next frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (frm_valid) begin
      hit_q <= hit_d;
      seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_cnt_q <= 16'h0000;
    end else if (frm_valid && hit_d) begin
      hit_cnt_q <= hit_cnt_d;
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign hit_valid = hit_valid_q;
  assign hit = hit_q;
endmodule : aclm_entry_match
`default_nettype wire

// ==== test/aclm_entry_match_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module aclm_entry_match_checker (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic pready, // Ready
  input wire logic [31:0] prdata, // Read data
  input wire logic pslverr, // Error
  input wire logic frm_valid, // Frame in
  input wire logic hit_valid, // Verdict
  input wire logic hit // Hit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  verdict_latency_a: assert property (frm_valid |=> hit_valid)
    else $error("verdict missing after frame");
  verdict_cause_a: assert property (!frm_valid |=> !hit_valid)
    else $error("verdict without frame");
  hit_hold_a: assert property (!frm_valid |=> $stable(hit))
    else $error("hit changed without frame");
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready outside access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read answer");
endmodule : aclm_entry_match_checker
bind aclm_entry_match aclm_entry_match_checker aclm_entry_match_checker_i (.*);
`default_nettype wire

// ==== test/aclm_frame_src.sv ====
`timescale 1ns/100ps
`default_nettype none
module aclm_frame_src (
  input wire logic clk, // Clock
  output logic frm_valid, // Header valid
  output logic frm_is_arp, // ARP
  output logic frm_is_icmp, // ICMP
  output logic frm_is_tcp, // TCP
  output logic frm_is_udp, // UDP
  output logic [15:0] frm_arp_proto, // Protocol
  output logic [7:0] frm_icmp_type, // Type
  output logic [7:0] frm_icmp_code, // Code
  output logic [15:0] frm_src_port, // Source
  output logic [15:0] frm_dst_port, // Destination
  output logic [4:0] frm_tcp_flags // Flags
);
  logic [72:0] fld;
  assign {frm_is_arp, frm_is_icmp, frm_is_tcp, frm_is_udp, frm_arp_proto, frm_icmp_type,
    frm_icmp_code, frm_src_port, frm_dst_port, frm_tcp_flags} = fld;
  initial begin
    frm_valid = 1'b0;
    fld = '0;
  end
  task send(input logic [72:0] f);
    @(posedge clk);
    fld <= f;
    frm_valid <= 1'b1;
    @(posedge clk);
    // Fields are not held after the valid cycle
    fld <= ~f;
    frm_valid <= 1'b0;
  endtask : send
endmodule : aclm_frame_src
`default_nettype wire

// ==== test/test_acl_entry_l3l4_matcher.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_acl_entry_l3l4_matcher;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, frm_valid, hit_valid, hit, er, lx;
  logic frm_is_arp, frm_is_icmp, frm_is_tcp, frm_is_udp;
  logic [7:0] paddr, frm_icmp_type, frm_icmp_code;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] frm_arp_proto, frm_src_port, frm_dst_port;
  logic [4:0] frm_tcp_flags;
  logic [1:0] md [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0};
  logic [15:0] pv [6] = '{16'h0010, 16'h0011, 16'h000f, 16'h0010, 16'hffff, 16'h000f};
  logic xp [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  int err_count = 0;
  int num_checks = 0;
  int hcnt = 0;
  aclm_entry_match aclm_entry_match_i (.*);
  aclm_frame_src aclm_frame_src_i (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      err_count++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  task frm(input logic [3:0] ty, input logic [15:0] pr, input logic [15:0] ic,
    input logic [31:0] pt, input logic [4:0] fl, input logic ex);
    aclm_frame_src_i.send({ty, pr, ic, pt, fl});
    @(negedge clk);
    chk({hit_valid, hit}, {1'b1, ex});
    hcnt += ex;
    lx = ex;
  endtask : frm
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rchk(aclm_pkg::STATUS_OFS, 32'h0);
    rchk(aclm_pkg::TCP_FLAG_OFS, aclm_pkg::CFG_RST);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, aclm_pkg::ICMP_CFG_OFS, 32'hffff_ffff);
    rchk(aclm_pkg::ICMP_CFG_OFS, 32'h00ff_ff03);
    apb(1'b1, aclm_pkg::ICMP_CFG_OFS, 32'h0000_ff03);
    $display("registers done");
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, aclm_pkg::ARP_CFG_OFS, 32'(t));
      frm(4'h8, aclm_pkg::PROTO_IP, 16'h0, 32'h0, 5'h0, t != 1);
      frm(4'h8, 16'h0806, 16'h0, 32'h0, 5'h0, t != 2);
    end
    frm(4'h4, 16'h0, 16'hff00, 32'h0, 5'h0, 1'b1);
    frm(4'h4, 16'h0800, 16'hfe00, 32'h0, 5'h0, 1'b0);
    frm(4'h4, 16'h0800, 16'hff01, 32'h0, 5'h0, 1'b0);
    apb(1'b1, aclm_pkg::ICMP_CFG_OFS, 32'h0000_ff01);
    frm(4'h4, 16'h0, 16'hff05, 32'h0, 5'h0, 1'b1);
    frm(4'h2, 16'h0, 16'h0, 32'h0, 5'h0, 1'b1);
    $display("arp and icmp done");
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, aclm_pkg::SPORT_RANGE_OFS + 8'(8 * s), 32'hffff_0010);
      for (int k = 0; k < 6; k++) begin
        apb(1'b1, aclm_pkg::SPORT_MODE_OFS + 8'(8 * s), {30'h0, md[k]});
        frm(k[0] ? 4'h2 : 4'h1, 16'h0, 16'h0, {pv[k], 16'h0} >> (16 * s), 5'h0,
          xp[k]);
      end
    end
    apb(1'b1, aclm_pkg::SPORT_RANGE_OFS, 32'h0000_0020);
    apb(1'b1, aclm_pkg::SPORT_MODE_OFS, 32'h0000_0002);
    frm(4'h1, 16'h0, 16'h0, 32'h0020_0000, 5'h0, 1'b0);
    apb(1'b1, aclm_pkg::SPORT_MODE_OFS, 32'h0000_0003);
    frm(4'h1, 16'h0, 16'h0, 32'h0020_0000, 5'h0, 1'b1);
    $display("ports done");
    for (int i = 0; i < 5; i++) begin
      for (int v = 1; v < 3; v++) begin
        apb(1'b1, aclm_pkg::TCP_FLAG_OFS, 32'(v) << (2 * i));
        frm(4'h2, 16'h0, 16'h0, 32'h0, 5'h1 << i, v == 2);
        frm(4'h2, 16'h0, 16'h0, 32'h0, 5'h0, v == 1);
        frm(4'h1, 16'h0, 16'h0, 32'h0, 5'h1 << i, 1'b1);
      end
    end
    apb(1'b1, aclm_pkg::TCP_FLAG_OFS, 32'h0000_03ff);
    frm(4'h2, 16'h0, 16'h0, 32'h0, 5'h1f, 1'b1);
    $display("flags done");
    apb(1'b1, aclm_pkg::STATUS_OFS, 32'hffff_ffff);
    chk(er, 1'b0);
    rchk(aclm_pkg::STATUS_OFS, {16'(hcnt), 14'h0, 1'b1, lx});
    $display("status done");
    end_sim();
  end
endmodule : test_acl_entry_l3l4_matcher
`default_nettype wire
